// *** hdl/cca_pkg.sv ***
package cca_pkg;
  // Register offsets on the host register port
  localparam logic [7:0] STRONG_SIGNAL_LIMIT_OFS   = 8'h12;
  localparam logic [7:0] BUSY_THRESHOLD_OFS        = 8'h13;
  localparam logic [7:0] ASSESSMENT_CONTROL_OFS    = 8'h15;
  localparam logic [7:0] ENERGY_RESULT_OFS         = 8'h16;
  localparam logic [7:0] QUIET_HOLD_LOW_OFS        = 8'h17;
  localparam logic [7:0] QUIET_HOLD_HIGH_OFS       = 8'h18;
  localparam logic [7:0] PACKET_OPTION_SETUP_OFS   = 8'h45;
  localparam logic [7:0] AUTO_REPLY_SETUP_OFS      = 8'h55;
  localparam logic [7:0] ADDRESS_FILTER_CONTROL_OFS = 8'h60;

  // Fields of assessment_control
  localparam int REPLY_ASSESSMENT_ENABLE_BIT = 7;
  localparam int REPEAT_RUN_HALT_BIT         = 6;
  localparam int REPEAT_RUN_SELECT_BIT       = 5;
  localparam int ASSESSMENT_ENABLE_BIT       = 4;
  localparam int IDLE_HUNT_SELECT_BIT        = 3;
  localparam int ASSESSMENT_FINISHED_BIT     = 2;
  localparam int VERDICT_HI_BIT              = 1;
  localparam int VERDICT_LO_BIT              = 0;

  // Other fields
  localparam int AUTO_ACK_ENABLE_BIT     = 4;
  localparam int MISMATCH_IDLE_HUNT_BIT  = 0;
  localparam int FILTER_ENABLE_HI_BIT    = 4;
  localparam int QUIET_HOLD_HIGH_HI_BIT  = 1;

  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    CCA_VERDICT_IDLE    = 2'h0,
    CCA_VERDICT_BUSY    = 2'h1,
    CCA_VERDICT_BLOCKED = 2'h3
  } cca_verdict_t;

  typedef enum {CCA_MODE_NORMAL, CCA_MODE_CONTINUOUS, CCA_MODE_IDLE_HUNT} cca_mode_t;
  typedef enum {CCA_ST_STOPPED, CCA_ST_RUNNING} cca_state_t;
endpackage

// *** hdl/cca_clear_channel.sv ***
// Notes on behaviour
// RQ1 - Three modes chosen by enable, hunt, repeat bits
// RQ2 - Receive-on with enable only starts normal mode
// RQ3 - Average above threshold gives BUSY, code 01
// RQ4 - Quiet for hold period gives IDLE, code 00
// RQ5 - Normal verdict sets finished and raises interrupt
// RQ6 - Normal verdict clears enable bit by itself
// RQ7 - Interrupt clear resets verdict to 00
// RQ8 - Host reads verdict before clearing interrupt
// RQ9 - Strong sample in window blocks IDLE
// RQ10 - Blocked window still allows BUSY verdict
// RQ11 - Blocked and below threshold shows code 11
// RQ12 - Blocked run continues until BUSY or IDLE
// RQ13 - Address mismatch with filter starts idle hunt
// RQ14 - Verdicts use averaged energy, readable by host
// RQ15 - Auto reply with assessment hunts idle first
// RQ16 - Continuous mode updates always, stops on halt
// RQ17 - Idle hunt finishes only on IDLE, clears bits
// RQ18 - Average equal to threshold is not busy
`timescale 1ns/100ps
module cca_clear_channel #(
  parameter int AVG_SHIFT = 3
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       rxOnCmd,
  input  wire logic       ackTxRequest,
  input  wire logic       addrMismatch,
  input  wire logic       sampleValid,
  input  wire logic [7:0] energySample,
  input  wire logic       completeIrqClear,
  output logic            completeIrq,
  output logic            assessRunning,
  output logic      [1:0] assessmentVerdict
);
  import cca_pkg::*;

  localparam int DEPTH = 1 << AVG_SHIFT;
  localparam int SUMW  = 8 + AVG_SHIFT;

  typedef struct packed {
    logic [7:0]              strongLimit;
    logic [7:0]              busyThreshold;
    logic                    replyEnable;
    logic                    repeatSelect;
    logic                    enable;
    logic                    idleHunt;
    logic                    finished;
    logic [1:0]              verdict;
    logic [7:0]              energyResult;
    logic [9:0]              quietHold;
    logic [7:0]              packetOption;
    logic [7:0]              autoReply;
    logic [7:0]              filterControl;
    logic [DEPTH-1:0][7:0]   window;
    logic [DEPTH-1:0]        strongMark;
    logic [SUMW-1:0]         sum;
    logic [AVG_SHIFT:0]      fillCnt;
    logic [9:0]              quietCnt;
    cca_state_t              state;
    cca_mode_t               mode;
    logic                    irq;
    logic [7:0]              rdData;
  } cca_regs_t;

  cca_regs_t st_reg;
  cca_regs_t st_next;

  function automatic logic [7:0] avgOf(input logic [SUMW-1:0] s);
    avgOf = s[SUMW-1:AVG_SHIFT];
  endfunction

  function automatic logic [7:0] controlView(input cca_regs_t s);
    controlView = {s.replyEnable, 1'b0, s.repeatSelect, s.enable,
                   s.idleHunt, s.finished, s.verdict};
  endfunction

  always_comb begin
    logic [SUMW-1:0] newSum;
    logic [7:0]      newAvg;
    logic            blocked;
    logic            isBusy;
    logic            quietDone;
    logic            startHunt;
    newSum    = '0;
    newAvg    = '0;
    blocked   = 1'b0;
    isBusy    = 1'b0;
    quietDone = 1'b0;
    startHunt = 1'b0;
    st_next     = st_reg;
    st_next.irq = 1'b0;

    if (regRdEn) begin
      unique case (regAddr)
        STRONG_SIGNAL_LIMIT_OFS:    st_next.rdData = st_reg.strongLimit;
        BUSY_THRESHOLD_OFS:         st_next.rdData = st_reg.busyThreshold;
        ASSESSMENT_CONTROL_OFS:     st_next.rdData = controlView(st_reg);
        ENERGY_RESULT_OFS:          st_next.rdData = st_reg.energyResult; // RQ14
        QUIET_HOLD_LOW_OFS:         st_next.rdData = st_reg.quietHold[7:0];
        QUIET_HOLD_HIGH_OFS:        st_next.rdData = {6'h00, st_reg.quietHold[9:8]};
        PACKET_OPTION_SETUP_OFS:    st_next.rdData = st_reg.packetOption;
        AUTO_REPLY_SETUP_OFS:       st_next.rdData = st_reg.autoReply;
        ADDRESS_FILTER_CONTROL_OFS: st_next.rdData = st_reg.filterControl;
        default:                    st_next.rdData = REG_RESET;
      endcase
    end

    if (regWrEn) begin
      unique case (regAddr)
        STRONG_SIGNAL_LIMIT_OFS:    st_next.strongLimit   = regWrData;
        BUSY_THRESHOLD_OFS:         st_next.busyThreshold = regWrData;
        QUIET_HOLD_LOW_OFS:         st_next.quietHold[7:0] = regWrData;
        QUIET_HOLD_HIGH_OFS:
          st_next.quietHold[9:8] = regWrData[QUIET_HOLD_HIGH_HI_BIT:0];
        PACKET_OPTION_SETUP_OFS:    st_next.packetOption  = regWrData;
        AUTO_REPLY_SETUP_OFS:       st_next.autoReply     = regWrData;
        ADDRESS_FILTER_CONTROL_OFS: st_next.filterControl = regWrData;
        ASSESSMENT_CONTROL_OFS: begin
          // Mode bits are only taken while stopped so a run never changes mode midway
          st_next.replyEnable = regWrData[REPLY_ASSESSMENT_ENABLE_BIT];
          if (st_reg.state == CCA_ST_STOPPED) begin
            st_next.repeatSelect = regWrData[REPEAT_RUN_SELECT_BIT];
            st_next.enable       = regWrData[ASSESSMENT_ENABLE_BIT];
            st_next.idleHunt     = regWrData[IDLE_HUNT_SELECT_BIT];
          end
          if (regWrData[REPEAT_RUN_HALT_BIT] && st_reg.mode == CCA_MODE_CONTINUOUS) begin
            st_next.state  = CCA_ST_STOPPED; // RQ16
            st_next.enable = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Verdict clear comes first so a verdict landing the same cycle survives
    if (completeIrqClear) begin
      st_next.verdict  = CCA_VERDICT_IDLE; // RQ7
      st_next.finished = 1'b0;
    end

    startHunt = (st_reg.autoReply[AUTO_ACK_ENABLE_BIT] && st_reg.replyEnable
                 && ackTxRequest) // RQ15
             || ((|st_reg.filterControl[FILTER_ENABLE_HI_BIT:0])
                 && st_reg.packetOption[MISMATCH_IDLE_HUNT_BIT] && addrMismatch); // RQ13

    if (st_reg.state == CCA_ST_STOPPED && (startHunt || (rxOnCmd && st_reg.enable))) begin
      st_next.state    = CCA_ST_RUNNING;
      st_next.fillCnt  = '0;
      st_next.quietCnt = '0;
      st_next.finished = 1'b0;
      if (startHunt) begin
        st_next.mode = CCA_MODE_IDLE_HUNT;
      end else if (st_reg.idleHunt && !st_reg.repeatSelect) begin
        st_next.mode = CCA_MODE_IDLE_HUNT; // RQ1
      end else if (st_reg.repeatSelect && !st_reg.idleHunt) begin
        st_next.mode = CCA_MODE_CONTINUOUS; // RQ1
      end else begin
        st_next.mode = CCA_MODE_NORMAL; // RQ2
      end
    end

    if (sampleValid) begin
      newSum = st_reg.sum + SUMW'(energySample) - SUMW'(st_reg.window[DEPTH-1]);
      newAvg = avgOf(newSum);
      st_next.sum        = newSum;
      st_next.window     = {st_reg.window[DEPTH-2:0], energySample};
      st_next.strongMark = {st_reg.strongMark[DEPTH-2:0],
                            energySample > st_reg.strongLimit};
      st_next.energyResult = newAvg; // RQ14
      blocked = |st_next.strongMark; // RQ9
      isBusy  = newAvg > st_reg.busyThreshold; // RQ18

      if (st_reg.state == CCA_ST_RUNNING) begin
        // No verdict until the window holds samples of this run only
        if (st_reg.fillCnt != (AVG_SHIFT+1)'(DEPTH)) begin
          st_next.fillCnt = st_reg.fillCnt + 1'b1;
        end
        if (isBusy) begin
          st_next.quietCnt = '0;
        end else if (st_reg.quietCnt != '1) begin
          st_next.quietCnt = st_reg.quietCnt + 1'b1;
        end
        quietDone = st_reg.quietCnt >= st_reg.quietHold; // RQ4
        // This sample completes the window once DEPTH-1 earlier run samples are in
        if (st_reg.fillCnt >= (AVG_SHIFT+1)'(DEPTH - 1)) begin
          if (isBusy) begin
            st_next.verdict = CCA_VERDICT_BUSY; // RQ3 RQ10
            if (st_reg.mode == CCA_MODE_NORMAL) begin
              st_next.finished = 1'b1; // RQ5
              st_next.irq      = 1'b1;
              st_next.enable   = 1'b0; // RQ6
              st_next.state    = CCA_ST_STOPPED;
            end
          end else if (blocked) begin
            st_next.verdict = CCA_VERDICT_BLOCKED; // RQ11 RQ12
          end else if (quietDone) begin
            st_next.verdict = CCA_VERDICT_IDLE; // RQ4
            if (st_reg.mode != CCA_MODE_CONTINUOUS) begin
              st_next.finished = 1'b1; // RQ5 RQ17
              st_next.irq      = 1'b1;
              st_next.enable   = 1'b0; // RQ6 RQ17
              st_next.state    = CCA_ST_STOPPED;
              if (st_reg.mode == CCA_MODE_IDLE_HUNT) begin
                st_next.idleHunt = 1'b0; // RQ17
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.state <= CCA_ST_STOPPED;
      st_reg.mode  <= CCA_MODE_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData         = st_reg.rdData;
  assign completeIrq       = st_reg.irq;
  assign assessRunning     = st_reg.state == CCA_ST_RUNNING;
  assign assessmentVerdict = st_reg.verdict;
endmodule

// *** verification/cca_clear_channel_monitor.sv ***
`timescale 1ns/100ps
module cca_clear_channel_monitor (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       rxOnCmd,
  input wire logic       ackTxRequest,
  input wire logic       addrMismatch,
  input wire logic       sampleValid,
  input wire logic       completeIrqClear,
  input wire logic       completeIrq,
  input wire logic       assessRunning,
  input wire logic [1:0] assessmentVerdict
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse;
    completeIrq ##1 !completeIrq;
  endsequence
  sequence s_start;
    rxOnCmd || ackTxRequest || addrMismatch;
  endsequence
  AST_IRQ_PULSE: assert property (completeIrq |-> s_pulse)
    else $error("interrupt longer than one cycle");
  AST_IRQ_STOP: assert property (completeIrq |-> !assessRunning)
    else $error("still running at completion");
  AST_IRQ_VERDICT: assert property (completeIrq |-> assessmentVerdict != 2'h3)
    else $error("completion with ongoing verdict");
  AST_CLEAR: assert property (completeIrqClear && !assessRunning |=> assessmentVerdict == 2'h0)
    else $error("verdict kept after interrupt clear");
  AST_START: assert property ($rose(assessRunning) |-> $past(rxOnCmd || ackTxRequest || addrMismatch))
    else $error("run began without a start request");
  AST_IRQ_CAUSE: assert property (completeIrq |-> $past(sampleValid) && $past(assessRunning))
    else $error("completion without a sample");
  AST_STABLE: assert property (!assessRunning && !completeIrqClear
    && !(rxOnCmd || ackTxRequest || addrMismatch) |=> $stable(assessmentVerdict))
    else $error("verdict moved while stopped");
  AST_BLOCKED_RUN: assert property (assessmentVerdict == 2'h3 |-> assessRunning)
    else $error("ongoing verdict while stopped");
endmodule

// *** verification/cca_clear_channel_bench.sv ***
`timescale 1ns/100ps
module cca_clear_channel_bench;
  import cca_pkg::*;
  typedef struct packed {logic [7:0] thr; logic [7:0] smp; logic [1:0] verd;} cca_row_t;
  logic       mclk, rst_n, regWrEn, regRdEn, rxOnCmd, ackTxRequest, addrMismatch;
  logic       sampleValid, completeIrqClear, completeIrq, assessRunning;
  logic [7:0] regAddr, regWrData, regRdData, energySample, rdVal;
  logic [1:0] assessmentVerdict;
  int         failures = 0, samples_checked = 0, irqCount = 0, base;
  logic [7:0] ofs [10] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h45, 8'h55, 8'h60, 8'h20};
  cca_row_t   rows [4] = '{'{8'h40, 8'h50, CCA_VERDICT_BUSY}, '{8'h40, 8'h40, CCA_VERDICT_IDLE},
                           '{8'h40, 8'h30, CCA_VERDICT_IDLE}, '{8'hFE, 8'hFF, CCA_VERDICT_BUSY}};
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (completeIrq === 1'b1) irqCount <= irqCount + 1;
  cca_clear_channel #(.AVG_SHIFT(1)) DUT (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .rxOnCmd(rxOnCmd), .ackTxRequest(ackTxRequest), .addrMismatch(addrMismatch),
    .sampleValid(sampleValid), .energySample(energySample),
    .completeIrqClear(completeIrqClear), .completeIrq(completeIrq),
    .assessRunning(assessRunning), .assessmentVerdict(assessmentVerdict));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge mclk) regWrEn = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk) {regAddr, regRdEn} = {a, 1'b1};
    @(negedge mclk) regRdEn = 0;
    rdVal = regRdData;
  endtask
  task automatic pulse(input logic [3:0] p);
    @(negedge mclk) {rxOnCmd, ackTxRequest, addrMismatch, completeIrqClear} = p;
    @(negedge mclk) {rxOnCmd, ackTxRequest, addrMismatch, completeIrqClear} = 4'h0;
  endtask
  // Data line is scrambled between samples so a stale value cannot pass
  task automatic smp(input logic [7:0] v, input int n);
    repeat (n) begin
      @(negedge mclk) {energySample, sampleValid} = {v, 1'b1};
      @(negedge mclk) {energySample, sampleValid} = {~v, 1'b0};
    end
  endtask
  task automatic now(input logic r, input logic [1:0] v);
    @(negedge mclk);
    chk("running", r, assessRunning);
    chk("verdict", v, assessmentVerdict);
  endtask
  // Called right after the deciding sample: the one-cycle interrupt stands now
  task automatic fin(input logic [1:0] v);
    chk("irq", 1, completeIrq);
    chk("verdict", v, assessmentVerdict);
    chk("running", 0, assessRunning);
  endtask
  task automatic clr();
    pulse(4'h1);
    chk("cleared verdict", 0, assessmentVerdict);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {mclk, rst_n, regWrEn, regRdEn, rxOnCmd, ackTxRequest, addrMismatch} = '0;
    {sampleValid, completeIrqClear, regAddr, regWrData, energySample} = '0;
    repeat (4) @(posedge mclk);
    @(negedge mclk) rst_n = 1;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reset value", REG_RESET, rdVal);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20);
    chk("unmapped", 8'h00, rdVal);
    pulse(4'h8);
    chk("start without enable", 0, assessRunning);
    $display("reset test done");
    wr(8'h12, 8'hFF);
    foreach (rows[i]) begin
      wr(8'h13, rows[i].thr);
      wr(8'h15, 8'h10);
      pulse(4'h8);
      chk("start", 1, assessRunning);
      smp(rows[i].smp, 2);
      fin(rows[i].verd);
      rd(8'h15);
      chk("control", {6'h01, rows[i].verd}, rdVal);
      clr();
    end
    $display("table test done");
    wr(8'h12, 8'h80);
    wr(8'h13, 8'h60);
    wr(8'h15, 8'h10);
    pulse(4'h8);
    smp(8'h90, 1);
    smp(8'h00, 1);
    now(1, CCA_VERDICT_BLOCKED);
    rd(8'h16);
    chk("average", 8'h48, rdVal);
    smp(8'h00, 1);
    fin(CCA_VERDICT_IDLE);
    clr();
    wr(8'h15, 8'h10);
    pulse(4'h8);
    smp(8'h90, 2);
    fin(CCA_VERDICT_BUSY);
    clr();
    $display("strong test done");
    wr(8'h12, 8'hFF);
    wr(8'h13, 8'h40);
    wr(8'h17, 8'h03);
    wr(8'h15, 8'h10);
    pulse(4'h8);
    smp(8'h10, 4);
    now(1, CCA_VERDICT_IDLE);
    smp(8'h10, 1);
    fin(CCA_VERDICT_IDLE);
    clr();
    wr(8'h17, 8'h00);
    $display("hold test done");
    base = irqCount;
    wr(8'h15, 8'h30);
    pulse(4'h8);
    smp(8'h50, 2);
    now(1, CCA_VERDICT_BUSY);
    smp(8'h10, 1);
    now(1, CCA_VERDICT_IDLE);
    chk("no irq", 0, 8'(irqCount - base));
    wr(8'h15, 8'h40);
    @(negedge mclk);
    chk("halted", 0, assessRunning);
    rd(8'h15);
    chk("finished", 0, rdVal & 8'h04);
    $display("continuous test done");
    wr(8'h15, 8'h00);
    wr(8'h60, 8'h01);
    wr(8'h45, 8'h01);
    pulse(4'h2);
    chk("hunt start", 1, assessRunning);
    smp(8'h50, 2);
    now(1, CCA_VERDICT_BUSY);
    smp(8'h10, 1);
    fin(CCA_VERDICT_IDLE);
    rd(8'h15);
    chk("control", 8'h04, rdVal);
    clr();
    wr(8'h55, 8'h10);
    wr(8'h15, 8'h80);
    pulse(4'h4);
    chk("reply start", 1, assessRunning);
    smp(8'h10, 2);
    fin(CCA_VERDICT_IDLE);
    clr();
    $display("hunt test done");
    report_and_stop();
  end
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule
bind cca_clear_channel cca_clear_channel_monitor CHK (.mclk(mclk), .rst_n(rst_n),
  .rxOnCmd(rxOnCmd), .ackTxRequest(ackTxRequest), .addrMismatch(addrMismatch),
  .sampleValid(sampleValid), .completeIrqClear(completeIrqClear), .completeIrq(completeIrq),
  .assessRunning(assessRunning), .assessmentVerdict(assessmentVerdict));
